// ---- hw/host_i2c_target.sv ----
// Purpose: Two-wire target that reads and writes an internal register port.
// Assumes: Register port answers read data combinationally from reg_addr.
// Notes:   Sub-address survives stop for two-phase reads.
`timescale 1ns/10ps
`default_nettype none
module host_i2c_target
  import host_i2c_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       addr_select_pin,
  host_i2c_if.target      bus,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_we,
  input  wire logic [7:0] reg_rdata,
  output var  logic       busy
);
  import host_i2c_pkg::*;

  typedef enum logic [2:0] {IDLE, ADDR, SUB, WDATA, RDATA, ACK_OUT, ACK_IN} state_t;

  // ----------------------------------------
  // Line synchronisers
  // ----------------------------------------
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic       scl_d_reg;
  logic       sda_d_reg;
  logic       rst_seen_reg;
  logic       sel_reg;
  logic [1:0] sel_sync_reg;

  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], bus.host_serial_clock_pin};
      sda_sync_reg <= {sda_sync_reg[0], bus.host_serial_data_pin};
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
    end

  wire scl  = scl_sync_reg[1];
  wire sda  = sda_sync_reg[1];
  wire scl_rise = scl & ~scl_d_reg;
  wire scl_fall = ~scl & scl_d_reg;
  wire start_det = scl & scl_d_reg & sda_d_reg & ~sda;
  wire stop_det  = scl & scl_d_reg & ~sda_d_reg & sda;

  // ----------------------------------------
  // Address select capture
  // ----------------------------------------
  // Pin loaded every clock under reset, last on first clock after release
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
      rst_seen_reg <= 1'b0;
    else
      rst_seen_reg <= 1'b1;

  // No reset, so the strap has settled through both stages by release
  always_ff @(posedge clock)
    sel_sync_reg <= {sel_sync_reg[0], addr_select_pin};

  always_ff @(posedge clock)
    if (!rst_seen_reg)
      sel_reg <= sel_sync_reg[1];

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  state_t     state_reg;
  state_t     after_ack_reg;
  logic [2:0] bit_reg;
  logic [7:0] shift_reg;
  logic [7:0] sub_reg;
  logic       sda_oe_n_reg;

  wire [7:0] byte_in   = {shift_reg[6:0], sda};
  wire       addr_hit  = byte_in[7:1] == target_addr(sel_reg);
  wire       byte_done = scl_rise & (bit_reg == BIT_LAST);

  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      state_reg     <= IDLE;
      after_ack_reg <= IDLE;
      bit_reg       <= 3'h0;
      shift_reg     <= 8'h00;
      sub_reg       <= SUBADDR_RESET;
      sda_oe_n_reg  <= 1'b1;
      reg_we        <= 1'b0;
      reg_wdata     <= 8'h00;
    end
    else
    begin
      reg_we <= 1'b0;
      if (start_det)
      begin
        state_reg    <= ADDR;
        bit_reg      <= 3'h0;
        sda_oe_n_reg <= 1'b1;
      end
      else if (stop_det)
      begin
        state_reg    <= IDLE;
        sda_oe_n_reg <= 1'b1;
      end
      else
        unique case (state_reg)
          IDLE: ;
          ADDR, SUB, WDATA:
            if (scl_rise)
            begin
              shift_reg <= byte_in;
              bit_reg   <= bit_reg + 3'h1;
              if (byte_done)
              begin
                if (state_reg == ADDR && !addr_hit)
                  state_reg <= IDLE;
                else
                begin
                  state_reg <= ACK_OUT;
                  if (state_reg == ADDR)
                    after_ack_reg <= byte_in[0] ? RDATA : SUB;
                  else if (state_reg == SUB)
                  begin
                    sub_reg       <= byte_in;
                    after_ack_reg <= WDATA;
                  end
                  else
                  begin
                    reg_wdata     <= byte_in;
                    reg_we        <= 1'b1;
                    after_ack_reg <= WDATA;
                  end
                end
              end
            end
          ACK_OUT:
            // Pull low only after clock has fallen; at next fall release, or drive bit 7 for a read
            if (scl_fall)
            begin
              if (sda_oe_n_reg)
                sda_oe_n_reg <= 1'b0;
              else
              begin
                state_reg <= after_ack_reg;
                bit_reg   <= 3'h0;
                if (after_ack_reg == RDATA)
                begin
                  shift_reg    <= {reg_rdata[6:0], 1'b0};
                  sda_oe_n_reg <= reg_rdata[7];
                end
                else
                  sda_oe_n_reg <= 1'b1;
              end
            end
            // Step only after the strobe has shown the old address
            else if (reg_we == 1'b1)
              sub_reg <= sub_reg + 8'h01;
          RDATA:
            if (scl_fall)
            begin
              bit_reg <= bit_reg + 3'h1;
              if (bit_reg == BIT_LAST)
              begin
                state_reg    <= ACK_IN;
                sda_oe_n_reg <= 1'b1;
                after_ack_reg <= IDLE;
                sub_reg      <= sub_reg + 8'h01;
              end
              else
              begin
                sda_oe_n_reg <= shift_reg[7];
                shift_reg    <= {shift_reg[6:0], 1'b0};
              end
            end
          ACK_IN:
            if (scl_rise)
            begin
              if (sda)
                state_reg <= IDLE;
              else
                after_ack_reg <= RDATA;
            end
            else if (scl_fall && after_ack_reg == RDATA)
            begin
              state_reg    <= RDATA;
              bit_reg      <= 3'h0;
              shift_reg    <= {reg_rdata[6:0], 1'b0};
              sda_oe_n_reg <= reg_rdata[7];
            end
          default: state_reg <= IDLE;
        endcase
    end

  // ACK_IN uses after_ack_reg as "master acked" flag; cleared on entry
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
      busy <= 1'b0;
    else
      busy <= state_reg != IDLE;

  assign reg_addr = sub_reg;
  assign bus.host_serial_data_pin_oe_n_s  = sda_oe_n_reg;
  assign bus.host_serial_clock_pin_oe_n_s = 1'b1;
endmodule
`default_nettype wire

// ---- shared/host_i2c_pkg.sv ----
// Purpose: Shared constants for the host two-wire target link and its master.
// Assumes: 25 MHz system clock on both ends.
// Notes:   Addresses are 7-bit; the low bit comes from the select pin.
package host_i2c_pkg;

  localparam logic [5:0] TARGET_ADDR_HI    = 6'h2E;
  localparam int         BYTE_BITS         = 8;
  localparam int         CLK_FREQ_HZ       = 25000000;
  localparam int         MAX_BIT_RATE_HZ   = 400000;
  localparam int         QUARTER_CYCLES    = CLK_FREQ_HZ / (4 * MAX_BIT_RATE_HZ) + 1;
  localparam logic [7:0] QUARTER_COUNT     = 8'(QUARTER_CYCLES);
  localparam logic [2:0] BIT_LAST          = 3'h7;
  localparam logic [7:0] SUBADDR_RESET     = 8'h00;

  function automatic logic [6:0] target_addr(input logic sel);
    target_addr = {TARGET_ADDR_HI, sel};
  endfunction

endpackage

// ---- shared/host_i2c_if.sv ----
// Purpose: Open-drain two-wire link between host master and target.
// Assumes: Each party gives out and output enable per line.
// Notes:   Enable low means the party pulls the line low.
`timescale 1ns/10ps
`default_nettype none
interface host_i2c_if;
  logic host_serial_clock_pin_oe_n_m;
  logic host_serial_data_pin_oe_n_m;
  logic host_serial_clock_pin_oe_n_s;
  logic host_serial_data_pin_oe_n_s;
  logic host_serial_clock_pin;
  logic host_serial_data_pin;

  // Wired-AND with pull-up
  assign host_serial_clock_pin = host_serial_clock_pin_oe_n_m & host_serial_clock_pin_oe_n_s;
  assign host_serial_data_pin  = host_serial_data_pin_oe_n_m & host_serial_data_pin_oe_n_s;

  modport target (
    input  host_serial_clock_pin,
    input  host_serial_data_pin,
    output host_serial_clock_pin_oe_n_s,
    output host_serial_data_pin_oe_n_s
  );
  modport master (
    input  host_serial_clock_pin,
    input  host_serial_data_pin,
    output host_serial_clock_pin_oe_n_m,
    output host_serial_data_pin_oe_n_m
  );
endinterface
`default_nettype wire

// ---- hw/host_i2c_master.sv ----
// Purpose: Host-side master issuing one byte-level bus operation at a time.
// Assumes: User sequences start, bytes and stop by command.
// Notes:   Bit rate set by quarter-period divider below 400 kbit/s.
`timescale 1ns/10ps
`default_nettype none
module host_i2c_master
  import host_i2c_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  host_i2c_if.master      bus,
  input  wire logic       cmd_valid,
  input  wire logic [1:0] cmd_op,
  input  wire logic [7:0] cmd_data,
  input  wire logic       cmd_nack,
  output var  logic       cmd_ready,
  output var  logic       rsp_valid,
  output var  logic [7:0] rsp_data,
  output var  logic       rsp_ack
);
  import host_i2c_pkg::*;

  // Operations: 0 start, 1 write byte, 2 read byte, 3 stop
  typedef enum logic [1:0] {OP_START, OP_WRITE, OP_READ, OP_STOP} op_t;
  typedef enum logic [1:0] {M_IDLE, M_RUN} mstate_t;

  logic [1:0] sda_sync_reg;
  logic       scl_oe_n_reg;
  logic       sda_oe_n_reg;
  logic [7:0] div_reg;
  logic [1:0] phase_reg;
  logic [3:0] bit_reg;
  logic [8:0] shift_reg;
  op_t        op_reg;
  mstate_t    state_reg;

  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
      sda_sync_reg <= 2'h3;
    else
      sda_sync_reg <= {sda_sync_reg[0], bus.host_serial_data_pin};

  wire tick     = div_reg == QUARTER_COUNT;
  wire last_bit = bit_reg == 4'(BYTE_BITS);

  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      state_reg    <= M_IDLE;
      op_reg       <= OP_START;
      scl_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
      div_reg      <= 8'h00;
      phase_reg    <= 2'h0;
      bit_reg      <= 4'h0;
      shift_reg    <= 9'h1FF;
      cmd_ready    <= 1'b0;
      rsp_valid    <= 1'b0;
      rsp_data     <= 8'h00;
      rsp_ack      <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      cmd_ready <= state_reg == M_IDLE && !(cmd_valid && cmd_ready);
      div_reg   <= (tick || state_reg == M_IDLE) ? 8'h00 : div_reg + 8'h01;
      unique case (state_reg)
        M_IDLE:
          if (cmd_valid && cmd_ready)
          begin
            op_reg    <= op_t'(cmd_op);
            state_reg <= M_RUN;
            phase_reg <= 2'h0;
            bit_reg   <= 4'h0;
            // Reads shift out all ones plus our ack choice
            shift_reg <= (cmd_op == 2'(OP_READ)) ? {8'hFF, cmd_nack} : {cmd_data, 1'b1};
          end
        M_RUN:
          if (tick)
          begin
            phase_reg <= phase_reg + 2'h1;
            unique case (op_reg)
              OP_START:
                unique case (phase_reg)
                  2'h0: sda_oe_n_reg <= 1'b1;
                  2'h1: scl_oe_n_reg <= 1'b1;
                  2'h2: sda_oe_n_reg <= 1'b0;
                  2'h3:
                  begin
                    scl_oe_n_reg <= 1'b0;
                    state_reg    <= M_IDLE;
                  end
                endcase
              OP_STOP:
                unique case (phase_reg)
                  2'h0: sda_oe_n_reg <= 1'b0;
                  2'h1: scl_oe_n_reg <= 1'b1;
                  2'h2: sda_oe_n_reg <= 1'b1;
                  2'h3: state_reg    <= M_IDLE;
                endcase
              OP_WRITE, OP_READ:
                unique case (phase_reg)
                  2'h0: sda_oe_n_reg <= shift_reg[8];
                  2'h1: scl_oe_n_reg <= 1'b1;
                  2'h2:
                  begin
                    shift_reg <= {shift_reg[7:0], sda_sync_reg[1]};
                    if (last_bit)
                      rsp_ack <= ~sda_sync_reg[1];
                  end
                  2'h3:
                  begin
                    scl_oe_n_reg <= 1'b0;
                    bit_reg      <= bit_reg + 4'h1;
                    if (last_bit)
                    begin
                      state_reg    <= M_IDLE;
                      sda_oe_n_reg <= 1'b1;
                      rsp_valid    <= 1'b1;
                      rsp_data     <= shift_reg[8:1];
                    end
                  end
                endcase
            endcase
          end
        default: state_reg <= M_IDLE;
      endcase
    end

  assign bus.host_serial_clock_pin_oe_n_m = scl_oe_n_reg;
  assign bus.host_serial_data_pin_oe_n_m  = sda_oe_n_reg;
endmodule
`default_nettype wire

// ---- dv/host_i2c_chk.sv ----
// Purpose: Protocol checks on the host two-wire link.
// Assumes: Both ends are design modules on one interface.
// Notes:   Rate check counts clocks between clock-line rises.
`timescale 1ns/10ps
`default_nettype none
module host_i2c_chk (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic host_serial_clock_pin,
  input wire logic host_serial_data_pin,
  input wire logic host_serial_clock_pin_oe_n_m,
  input wire logic host_serial_data_pin_oe_n_m,
  input wire logic host_serial_clock_pin_oe_n_s,
  input wire logic host_serial_data_pin_oe_n_s
);
  logic       scl;
  logic       sda;
  logic       tdo;
  logic       rise;
  logic       scl_q_reg;
  logic       seen_reg;
  logic [7:0] gap_reg;
  logic [7:0] gap_next;
  assign scl = host_serial_clock_pin;
  assign sda = host_serial_data_pin;
  assign tdo = host_serial_data_pin_oe_n_s;
  assign rise = scl & ~scl_q_reg;
  assign gap_next = rise ? 8'h01 : (gap_reg == 8'hFF) ? gap_reg : gap_reg + 8'h01;
  // Saturating count; a bit period is too long for a repetition
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      scl_q_reg <= 1'b1;
      seen_reg  <= 1'b0;
      gap_reg   <= 8'h00;
    end
    else
    begin
      scl_q_reg <= scl;
      seen_reg  <= seen_reg | rise;
      gap_reg   <= gap_next;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  a_scl_never_driven: assert property (host_serial_clock_pin_oe_n_s)
    else $error("target pulled the clock line");
  a_drive_when_low: assert property ($fell(tdo) |-> !scl)
    else $error("target pulled data while clock high");
  a_rate_limit: assert property (rise && seen_reg |-> gap_reg >= 8'h3F)
    else $error("clock line period too short");
  a_data_stable_high: assert property (scl && $past(scl) |-> $stable(tdo))
    else $error("target data changed while clock high");
  a_start_then_low: assert property (scl && $fell(sda) |-> ##[1:40] !scl)
    else $error("no clock low after start");
  a_stop_released: assert property (scl && $rose(sda) |-> tdo [*8])
    else $error("target holds data after stop");
  a_master_clocks: assert property (scl == host_serial_clock_pin_oe_n_m)
    else $error("clock line not from master");
  a_ack_held: assert property ($rose(scl) && !tdo |-> !tdo [*8])
    else $error("target low bit not held");
  c_start: cover property (scl && $fell(sda));
  c_stop: cover property (scl && $rose(sda));
  c_target_low: cover property ($rose(scl) && !tdo);
  c_master_low: cover property ($rose(scl) && !host_serial_data_pin_oe_n_m);
endmodule
`default_nettype wire

// ---- dv/test_host_i2c_slave_interface.sv ----
// Purpose: Master and target face each other; bench checks both user sides.
// Assumes: Register file reads back address XOR 3Ch.
// Notes:   Driver queues expected results; monitor pops and compares.
`timescale 1ns/10ps
`default_nettype none
module test_host_i2c_slave_interface;
  import host_i2c_pkg::*;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        addr_select_pin = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [1:0]  cmd_op = 2'h0;
  logic [7:0]  cmd_data = 8'h00;
  logic        cmd_nack = 1'b0;
  logic [7:0]  reg_rdata = 8'h00;
  logic        cmd_ready, rsp_valid, rsp_ack, reg_we, busy;
  logic [7:0]  rsp_data, reg_addr, reg_wdata;
  logic [31:0] rng = 32'h0000044C;
  logic [9:0]  e;
  logic [15:0] w;
  logic [9:0]  rsp_q[$];
  logic [15:0] wr_q[$];
  int          fails = 0;
  int          samples_checked = 0;
  host_i2c_if link ();
  host_i2c_target i_host_i2c_target (.clock(clock), .sys_rst(sys_rst),
    .addr_select_pin(addr_select_pin), .bus(link), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata), .busy(busy));
  host_i2c_master i_host_i2c_master (.clock(clock), .sys_rst(sys_rst), .bus(link),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_nack(cmd_nack),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
  host_i2c_chk i_host_i2c_chk (.clock(clock), .sys_rst(sys_rst),
    .host_serial_clock_pin(link.host_serial_clock_pin),
    .host_serial_data_pin(link.host_serial_data_pin),
    .host_serial_clock_pin_oe_n_m(link.host_serial_clock_pin_oe_n_m),
    .host_serial_data_pin_oe_n_m(link.host_serial_data_pin_oe_n_m),
    .host_serial_clock_pin_oe_n_s(link.host_serial_clock_pin_oe_n_s),
    .host_serial_data_pin_oe_n_s(link.host_serial_data_pin_oe_n_s));
  initial
  begin
    forever #20 clock = ~clock;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // ----------------------------------------
  // Monitor and register file
  // ----------------------------------------
  // An unexpected result pops an unknown note and so mismatches
  always @(posedge clock)
  begin
    reg_rdata <= reg_addr ^ 8'h3C;
    if (rsp_valid === 1'b1)
    begin
      e = (rsp_q.size() != 0) ? rsp_q.pop_front() : 10'bx;
      check("response", {6'h00, e[9], rsp_ack, e[9] ? rsp_data : e[7:0]}, {6'h00, e});
    end
    if (reg_we === 1'b1)
    begin
      w = (wr_q.size() != 0) ? wr_q.pop_front() : 16'bx;
      check("register write", {reg_addr, reg_wdata}, w);
    end
  end
  task automatic cmd(input logic [1:0] op, input logic [7:0] d, input logic nk,
                     input logic [9:0] x);
    int n;
    n = 0;
    if (op == 2'h1 || op == 2'h2)
      rsp_q.push_back(x);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_data  <= d;
    cmd_nack  <= nk;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (cmd_ready !== 1'b1 && n < 3000);
    if (n >= 3000)
      fails++;
    cmd_valid <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wbyte(input logic [7:0] d, input logic ack);
    cmd(2'h1, d, 1'b0, {1'b0, ack, 8'h00});
  endtask
  task automatic rbyte(input logic [7:0] d, input logic nk);
    cmd(2'h2, 8'h00, nk, {1'b1, ~nk, d});
  endtask
  task automatic finish_test(input string name);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 3000)
    begin
      @(posedge clock);
      n++;
    end
    repeat (4) @(posedge clock);
    check("pending notes", 16'(rsp_q.size() + wr_q.size()), 16'h0000);
    check("idle lines", {13'h0, busy, link.host_serial_clock_pin,
          link.host_serial_data_pin}, 16'h0003);
    $display("Test %s done", name);
  endtask
  // ----------------------------------------
  // Scenarios, once per address choice
  // ----------------------------------------
  task automatic run(input logic sel);
    logic [7:0] dev;
    logic [7:0] s;
    sys_rst         <= 1'b1;
    addr_select_pin <= sel;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    addr_select_pin <= ~sel;
    dev = 8'hB8 | {6'h00, sel, 1'b0};
    rng = xs(rng);
    s = rng[7:0];
    cmd(2'h0, 8'h00, 1'b0, 10'h000);
    wbyte(dev, 1'b1);
    wbyte(s, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      rng = xs(rng);
      wr_q.push_back({s + 8'(k), rng[7:0]});
      wbyte(rng[7:0], 1'b1);
    end
    cmd(2'h3, 8'h00, 1'b0, 10'h000);
    finish_test("block write");
    cmd(2'h0, 8'h00, 1'b0, 10'h000);
    wbyte(dev ^ 8'h02, 1'b0);
    wbyte(8'h55, 1'b0);
    cmd(2'h3, 8'h00, 1'b0, 10'h000);
    finish_test("foreign address");
    cmd(2'h0, 8'h00, 1'b0, 10'h000);
    wbyte(dev, 1'b1);
    wbyte(s, 1'b1);
    cmd(2'h3, 8'h00, 1'b0, 10'h000);
    cmd(2'h0, 8'h00, 1'b0, 10'h000);
    wbyte(dev | 8'h01, 1'b1);
    for (int k = 0; k < 3; k++)
      rbyte((s + 8'(k)) ^ 8'h3C, k == 2);
    cmd(2'h3, 8'h00, 1'b0, 10'h000);
    finish_test("two-phase read");
    rng = xs(rng);
    cmd(2'h0, 8'h00, 1'b0, 10'h000);
    wbyte(dev, 1'b1);
    wbyte(rng[7:0], 1'b1);
    cmd(2'h0, 8'h00, 1'b0, 10'h000);
    wbyte(dev | 8'h01, 1'b1);
    rbyte(rng[7:0] ^ 8'h3C, 1'b1);
    cmd(2'h3, 8'h00, 1'b0, 10'h000);
    finish_test("repeated start");
  endtask
  task automatic test_done();
    $display("Checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    run(1'b0);
    run(1'b1);
    test_done();
  end
  initial
  begin
    #4000000;
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
